// *** rtl/evq_defines.svh ***
`ifndef EVQ_DEFINES_SVH
`define EVQ_DEFINES_SVH
// ----------------------------------------
// Entry codes, bit 3 set marks a status
// ----------------------------------------
`define EVQ_CODE_BREAK 4'h0
`define EVQ_CODE_SIGNAL 4'h1
`define EVQ_CODE_TXDONE 4'h2
`define EVQ_CODE_SWITCH 4'h8
`define EVQ_CODE_EOD 4'h9
`define EVQ_STATUS_BIT 3
// ----------------------------------------
// Priorities, smaller value ranks higher
// ----------------------------------------
`define EVQ_PRIO_BREAK 4'h1
`define EVQ_PRIO_SIGNAL 4'h2
`define EVQ_PRIO_EVENT 4'h3
`define EVQ_PRIO_REQUEST 4'h8
// ----------------------------------------
// Reset values
// ----------------------------------------
`define EVQ_ENABLE_RESET 8'hFF
`endif

// *** rtl/evq_pkg.sv ***
package evq_pkg;
    // Which queue a pool slot belongs to
    typedef enum logic [1:0]
    {
        Q_FREE = 2'b00,
        Q_REPORT = 2'b01,
        Q_HELD = 2'b10
    } queue_t;
    // Kind of answer to a status poll
    typedef enum logic [1:0]
    {
        RESP_IDLE = 2'b00,
        RESP_ACTIVE = 2'b01,
        RESP_QUEUED = 2'b10
    } resp_t;
endpackage : evq_pkg

// *** rtl/event_queue_status_reporter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "evq_defines.svh"

// Behaviour
// - Status-change blocks always go to the status report queue.
// - Event for an enabled port is reported, then that port's enable clears.
// - Event for a disabled port waits in the held queue until acknowledged.
// - Both queues are ordered by priority; the head is the highest priority.
// - Events rank above requests; line break ranks above signal character.
// - Internal port number is replaced by the host port identifier.
// - Allocation with an empty pool enters a permanent halt.
// - Freeing a block is atomic against the event sources.
// - Invalidation removes a matching event, never a status, and frees it.
// - Invalidation tries the report queue first, then the held queue.
// - After removal from report queue, clear queued flag and move the port's held head to report queue.
// - Poll with no active transaction and empty queue answers idle.
// - Active transaction ranking at or above the head is reported; queue unchanged.
// - Higher-priority head: queue the active status, send the head.
// - Requests share one priority below all events; priorities stay settable.
// - A sent switch or end-of-data makes its tag the active transaction.
// - A sent event clears that port's event status bit for its code.
// - Any other sent entry clears the active transaction.
// - Every finished order raises a service request for the next one.
// - Detected line break with reporting enabled submits a break event.
// - Drained transmit buffer submits an event if enabled, else wakes the write.
// - Acknowledge with the port's queued flag clear moves its held head to report queue, or enables events if none is held.
module event_queue_status_reporter #(
    parameter int NSLOT = 16
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sub_valid_i,
    output logic sub_ready_o,
    input wire logic [3:0] sub_code_i,
    input wire logic [2:0] sub_port_i,
    input wire logic [15:0] sub_tag_i,
    input wire logic [3:0] sub_prio_i,
    input wire logic [7:0] break_i,
    input wire logic [7:0] break_report_en_i,
    input wire logic [7:0] tx_drained_i,
    input wire logic [7:0] tx_event_en_i,
    output logic [7:0] write_wake_o,
    input wire logic [63:0] port_identifier_map_i,
    input wire logic poll_i,
    input wire logic event_acknowledge_i,
    input wire logic invalidate_i,
    input wire logic [7:0] order_pid_i,
    input wire logic [3:0] inv_code_i,
    output logic resp_valid_o,
    output evq_pkg::resp_t resp_kind_o,
    output logic [3:0] resp_code_o,
    output logic [7:0] resp_pid_o,
    output logic [15:0] resp_tag_o,
    output logic active_valid_o,
    output logic [15:0] active_tag_o,
    output logic [7:0] event_enable_o,
    output logic [63:0] event_status_o,
    output logic service_request_o,
    output logic halt_o
);
    localparam int IW = (NSLOT > 1) ? $clog2(NSLOT) : 1;
    if (NSLOT < 2 || NSLOT > 256)
    begin : g_check
        $error("NSLOT must lie between 2 and 256");
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Ordering: lower priority value first, then older sequence
    function automatic logic ahead(input logic [3:0] pa, input logic [15:0] sa,
                                   input logic [3:0] pb, input logic [15:0] sb);
        logic [15:0] d;
        d = sa - sb;
        return (pa < pb) || (pa == pb && d[15]);
    endfunction : ahead
    // Host identifier of an internal port
    function automatic logic [7:0] port_to_pid(input logic [63:0] m, input logic [2:0] p);
        return m[{p, 3'b000} +: 8];
    endfunction : port_to_pid
    // Lowest set bit of a per-port mask
    function automatic logic [2:0] low_port(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int p = 7; p >= 0; p--)
            if (v[p])
                r = 3'(p);
        return r;
    endfunction : low_port
    // ----------------------------------------
    // State
    // ----------------------------------------
    evq_pkg::queue_t s_q [NSLOT];
    logic [3:0] s_code [NSLOT];
    logic [7:0] s_pid [NSLOT];
    logic [2:0] s_port [NSLOT];
    logic [15:0] s_tag [NSLOT];
    logic [3:0] s_prio [NSLOT];
    logic [15:0] s_seq [NSLOT];
    logic [15:0] seq_reg;
    logic [7:0] enable_reg, queued_reg, brk_pend_reg, drn_pend_reg, wake_reg;
    logic [63:0] evstat_reg;
    logic act_reg, halt_reg, srq_reg, rv_reg;
    logic [3:0] act_code_reg, act_prio_reg, rcode_reg;
    logic [7:0] act_pid_reg, rpid_reg;
    logic [2:0] act_port_reg;
    logic [15:0] act_tag_reg, rtag_reg;
    evq_pkg::resp_t rkind_reg;
    // ----------------------------------------
    // Order port lookup
    // ----------------------------------------
    logic ord_found;
    logic [2:0] ord_port;
    always_comb
    begin
        ord_found = 1'b0;
        ord_port = 3'd0;
        for (int p = 0; p < 8; p++)
        begin
            if (!ord_found && port_to_pid(port_identifier_map_i, 3'(p)) == order_pid_i)
            begin
                ord_found = 1'b1;
                ord_port = 3'(p);
            end
        end
    end
    // ----------------------------------------
    // Pool searches
    // ----------------------------------------
    logic free_ok, head_ok, hp_ok, ism_ok, ihm_ok;
    logic [IW-1:0] free_idx, head_idx, hp_idx, ism_idx, ihm_idx;
    always_comb
    begin
        free_ok = 1'b0;
        head_ok = 1'b0;
        hp_ok = 1'b0;
        ism_ok = 1'b0;
        ihm_ok = 1'b0;
        free_idx = '0;
        head_idx = '0;
        hp_idx = '0;
        ism_idx = '0;
        ihm_idx = '0;
        for (int i = 0; i < NSLOT; i++)
        begin
            if (s_q[i] == evq_pkg::Q_FREE && !free_ok)
            begin
                free_ok = 1'b1;
                free_idx = IW'(i);
            end
            if (s_q[i] == evq_pkg::Q_REPORT &&
                (!head_ok || ahead(s_prio[i], s_seq[i], s_prio[head_idx], s_seq[head_idx])))
            begin
                head_ok = 1'b1;
                head_idx = IW'(i);
            end
            if (s_q[i] == evq_pkg::Q_HELD && s_port[i] == ord_port &&
                (!hp_ok || ahead(s_prio[i], s_seq[i], s_prio[hp_idx], s_seq[hp_idx])))
            begin
                hp_ok = 1'b1;
                hp_idx = IW'(i);
            end
            // Only events match, never a status entry
            if (!s_code[i][`EVQ_STATUS_BIT] && s_port[i] == ord_port && s_code[i] == inv_code_i)
            begin
                if (s_q[i] == evq_pkg::Q_REPORT && !ism_ok)
                begin
                    ism_ok = 1'b1;
                    ism_idx = IW'(i);
                end
                if (s_q[i] == evq_pkg::Q_HELD && !ihm_ok)
                begin
                    ihm_ok = 1'b1;
                    ihm_idx = IW'(i);
                end
            end
        end
    end
    // ----------------------------------------
    // Submission source selection
    // ----------------------------------------
    wire brk_any = |brk_pend_reg;
    wire drn_any = |drn_pend_reg;
    wire [2:0] brk_port = low_port(brk_pend_reg);
    wire [2:0] drn_port = low_port(drn_pend_reg);
    wire order_any = poll_i | event_acknowledge_i | invalidate_i;
    wire live = !halt_reg;
    wire take_ext = sub_valid_i && !order_any && live;
    wire take_brk = !sub_valid_i && brk_any && !order_any && live;
    wire take_drn = !sub_valid_i && !brk_any && drn_any && !order_any && live;
    wire src_v = take_ext | take_brk | take_drn;
    wire [2:0] src_port = take_ext ? sub_port_i : (take_brk ? brk_port : drn_port);
    wire [3:0] src_code = take_ext ? sub_code_i : (take_brk ? `EVQ_CODE_BREAK : `EVQ_CODE_TXDONE);
    wire [3:0] src_prio = take_ext ? sub_prio_i : (take_brk ? `EVQ_PRIO_BREAK : `EVQ_PRIO_EVENT);
    wire [15:0] src_tag = take_ext ? sub_tag_i : 16'h0000;
    wire src_status = src_code[`EVQ_STATUS_BIT];
    wire src_direct = src_status || enable_reg[src_port];
    wire src_ev_direct = src_v && !src_status && enable_reg[src_port];
    // ----------------------------------------
    // Poll decision
    // ----------------------------------------
    wire do_poll = poll_i && live;
    wire p_active = act_reg && (!head_ok || !(s_prio[head_idx] < act_prio_reg));
    wire p_queue = head_ok && !p_active;
    wire p_park = do_poll && p_queue && act_reg;
    wire [3:0] h_code = s_code[head_idx];
    wire h_switch = h_code == `EVQ_CODE_SWITCH || h_code == `EVQ_CODE_EOD;
    wire h_event = !h_code[`EVQ_STATUS_BIT];
    // ----------------------------------------
    // Acknowledge and invalidation decisions
    // ----------------------------------------
    wire do_ack = event_acknowledge_i && !poll_i && live && ord_found;
    wire do_inv = invalidate_i && !poll_i && !event_acknowledge_i && live && ord_found;
    wire ack_move = do_ack && !queued_reg[ord_port] && hp_ok;
    wire ack_enable = do_ack && !queued_reg[ord_port] && !hp_ok;
    wire inv_move = do_inv && ism_ok && hp_ok;
    // ----------------------------------------
    // Pool write controls
    // ----------------------------------------
    wire need_alloc = src_v || p_park;
    wire al_en = need_alloc && free_ok;
    wire fr_en = (do_poll && p_queue) || (do_inv && (ism_ok || ihm_ok));
    wire [IW-1:0] fr_idx = do_poll ? head_idx : (ism_ok ? ism_idx : ihm_idx);
    wire mv_en = ack_move || inv_move;
    wire al_rep = p_park || src_direct;
    // Slot pool; a single-cycle free cannot interleave with a source
    always_ff @(posedge mclk_i)
    begin
        for (int i = 0; i < NSLOT; i++)
        begin
            if (rst_i)
                s_q[i] <= evq_pkg::Q_FREE;
            else if (fr_en && fr_idx == IW'(i))
                s_q[i] <= evq_pkg::Q_FREE;
            else if (mv_en && hp_idx == IW'(i))
            begin
                s_q[i] <= evq_pkg::Q_REPORT;
                s_seq[i] <= seq_reg;
            end
            else if (al_en && free_idx == IW'(i))
            begin
                s_q[i] <= al_rep ? evq_pkg::Q_REPORT : evq_pkg::Q_HELD;
                s_code[i] <= p_park ? act_code_reg : src_code;
                s_pid[i] <= p_park ? act_pid_reg : port_to_pid(port_identifier_map_i, src_port);
                s_port[i] <= p_park ? act_port_reg : src_port;
                s_tag[i] <= p_park ? act_tag_reg : src_tag;
                s_prio[i] <= p_park ? act_prio_reg : src_prio;
                s_seq[i] <= seq_reg;
            end
        end
    end
    // ----------------------------------------
    // Per-port flags
    // ----------------------------------------
    wire [7:0] sent_ev_port = (do_poll && p_queue && h_event) ? (8'h01 << s_port[head_idx]) : 8'h00;
    wire [63:0] evstat_set = (src_v && !src_status) ? (64'h1 << {src_port, src_code[2:0]}) : 64'h0;
    wire [63:0] evstat_clr = (do_poll && p_queue && h_event) ?
                             (64'h1 << {s_port[head_idx], h_code[2:0]}) : 64'h0;
    // Enables, queued flags and pending sources; sets win over clears
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            enable_reg <= `EVQ_ENABLE_RESET;
            queued_reg <= 8'h00;
            brk_pend_reg <= 8'h00;
            drn_pend_reg <= 8'h00;
            wake_reg <= 8'h00;
            evstat_reg <= 64'h0;
        end
        else
        begin
            enable_reg <= (enable_reg & ~(src_ev_direct ? (8'h01 << src_port) : 8'h00)) |
                          (ack_enable ? (8'h01 << ord_port) : 8'h00);
            queued_reg <= (queued_reg & ~sent_ev_port & ~((do_inv && ism_ok) ? (8'h01 << ord_port) : 8'h00)) |
                          (src_ev_direct ? (8'h01 << src_port) : 8'h00) |
                          (mv_en ? (8'h01 << ord_port) : 8'h00);
            brk_pend_reg <= (brk_pend_reg & ~(take_brk ? (8'h01 << brk_port) : 8'h00)) |
                            (break_i & break_report_en_i);
            drn_pend_reg <= (drn_pend_reg & ~(take_drn ? (8'h01 << drn_port) : 8'h00)) |
                            (tx_drained_i & tx_event_en_i);
            wake_reg <= tx_drained_i & ~tx_event_en_i;
            evstat_reg <= (evstat_reg & ~evstat_clr) | evstat_set;
        end
    end
    // ----------------------------------------
    // Active transaction and poll answer
    // ----------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            act_reg <= 1'b0; // Guards the unreset active fields
            act_tag_reg <= 16'h0000;
            rv_reg <= 1'b0;
            rkind_reg <= evq_pkg::RESP_IDLE;
            rcode_reg <= 4'h0;
            rpid_reg <= 8'h00;
            rtag_reg <= 16'h0000;
        end
        else
        begin
            rv_reg <= do_poll;
            if (do_poll && !act_reg && !head_ok)
                rkind_reg <= evq_pkg::RESP_IDLE;
            else if (do_poll && p_active)
            begin
                rkind_reg <= evq_pkg::RESP_ACTIVE;
                rcode_reg <= act_code_reg;
                rpid_reg <= act_pid_reg;
                rtag_reg <= act_tag_reg;
            end
            else if (do_poll && p_queue)
            begin
                rkind_reg <= evq_pkg::RESP_QUEUED;
                rcode_reg <= h_code;
                rpid_reg <= s_pid[head_idx];
                rtag_reg <= s_tag[head_idx];
                act_reg <= h_switch;
                if (h_switch)
                begin
                    act_code_reg <= h_code;
                    act_prio_reg <= s_prio[head_idx];
                    act_pid_reg <= s_pid[head_idx];
                    act_port_reg <= s_port[head_idx];
                    act_tag_reg <= s_tag[head_idx];
                end
            end
        end
    end
    // Sequence stamp, halt and order completion
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            seq_reg <= 16'h0000;
            halt_reg <= 1'b0;
            srq_reg <= 1'b0;
        end
        else
        begin
            seq_reg <= (al_en || mv_en) ? seq_reg + 16'h0001 : seq_reg;
            halt_reg <= halt_reg | (need_alloc & ~free_ok);
            srq_reg <= order_any && live;
        end
    end
    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign sub_ready_o = !order_any && live;
    assign write_wake_o = wake_reg;
    assign resp_valid_o = rv_reg;
    assign resp_kind_o = rkind_reg;
    assign resp_code_o = rcode_reg;
    assign resp_pid_o = rpid_reg;
    assign resp_tag_o = rtag_reg;
    assign active_valid_o = act_reg;
    assign active_tag_o = act_tag_reg;
    assign event_enable_o = enable_reg;
    assign event_status_o = evstat_reg;
    assign service_request_o = srq_reg;
    assign halt_o = halt_reg;
endmodule : event_queue_status_reporter
`default_nettype wire

// *** testbench/evq_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port-level checks of the event queue block
// ----------------------------------------
module evq_sva #(
    parameter int NSLOT = 16
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sub_valid_i,
    input wire logic sub_ready_o,
    input wire logic [3:0] sub_code_i,
    input wire logic [2:0] sub_port_i,
    input wire logic [7:0] tx_drained_i,
    input wire logic [7:0] tx_event_en_i,
    input wire logic [7:0] write_wake_o,
    input wire logic poll_i,
    input wire logic event_acknowledge_i,
    input wire logic invalidate_i,
    input wire logic resp_valid_o,
    input wire evq_pkg::resp_t resp_kind_o,
    input wire logic [3:0] resp_code_o,
    input wire logic [15:0] resp_tag_o,
    input wire logic active_valid_o,
    input wire logic [15:0] active_tag_o,
    input wire logic [7:0] event_enable_o,
    input wire logic [63:0] event_status_o,
    input wire logic service_request_o,
    input wire logic halt_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Orders and their answers
    AST_SRQ_AFTER_ORDER: assert property ((poll_i || event_acknowledge_i || invalidate_i) && !halt_o
        |=> service_request_o)
        else $error("no service request after an order");
    AST_RESP_ONLY_AFTER_POLL: assert property (resp_valid_o |-> $past(poll_i) && !$past(halt_o))
        else $error("response without a poll");
    AST_IDLE_NO_ACTIVE: assert property (resp_valid_o && resp_kind_o == evq_pkg::RESP_IDLE
        |-> !active_valid_o)
        else $error("idle answered with an active transaction");
    AST_ACTIVE_REPORTED: assert property (resp_valid_o && resp_kind_o == evq_pkg::RESP_ACTIVE
        |-> active_valid_o && resp_tag_o == active_tag_o)
        else $error("active report carries wrong tag");
    AST_SWITCH_ACTIVATES: assert property (resp_valid_o && resp_kind_o == evq_pkg::RESP_QUEUED
        && resp_code_o[3:1] == 3'h4 |-> active_valid_o && active_tag_o == resp_tag_o)
        else $error("switch did not activate its tag");
    AST_OTHER_CLEARS: assert property (resp_valid_o && resp_kind_o == evq_pkg::RESP_QUEUED
        && resp_code_o[3:1] != 3'h4 |-> !active_valid_o)
        else $error("active kept after non-switch entry");
    // Submissions
    AST_EVENT_DISABLES: assert property (sub_valid_i && sub_ready_o && !sub_code_i[3]
        |=> halt_o || !event_enable_o[$past(sub_port_i)])
        else $error("event enable not cleared");
    AST_EVENT_STATUS_SET: assert property (sub_valid_i && sub_ready_o && !sub_code_i[3]
        |=> halt_o || event_status_o[{$past(sub_port_i), $past(sub_code_i[2:0])}])
        else $error("event status bit not set");
    AST_WAKE: assert property ((tx_drained_i & ~tx_event_en_i) != 8'h00
        |=> write_wake_o == $past(tx_drained_i & ~tx_event_en_i))
        else $error("write wake does not follow drain");
    // Halt
    AST_HALT_STICKY: assert property (halt_o |=> halt_o)
        else $error("halt released without reset");
    AST_HALT_REFUSES: assert property (halt_o && (poll_i || event_acknowledge_i || invalidate_i)
        |=> !service_request_o && !resp_valid_o)
        else $error("order served while halted");
    // Main scenarios
    COV_IDLE: cover property (resp_valid_o && resp_kind_o == evq_pkg::RESP_IDLE);
    COV_ACTIVE: cover property (resp_valid_o && resp_kind_o == evq_pkg::RESP_ACTIVE);
    COV_HALT: cover property ($rose(halt_o));
endmodule : evq_sva
`default_nettype wire

// *** testbench/host_order_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host side: issues one order pulse at a time
// ----------------------------------------
module host_order_model (
    input wire logic mclk_i,
    output logic poll_o,
    output logic ack_o,
    output logic inv_o,
    output logic [7:0] pid_o,
    output logic [3:0] code_o
);
    initial
    begin
        poll_o = 1'b0;
        ack_o = 1'b0;
        inv_o = 1'b0;
        pid_o = 8'h00;
        code_o = 4'h0;
    end
    // Kind 0 poll, 1 acknowledge, 2 invalidate; ends at the taking edge
    task automatic order(input logic [1:0] kind, input logic [7:0] port_identifier, input logic [3:0] code);
        @(posedge mclk_i);
        poll_o <= (kind == 2'h0);
        ack_o <= (kind == 2'h1);
        inv_o <= (kind == 2'h2);
        pid_o <= port_identifier;
        code_o <= code;
        @(posedge mclk_i);
        poll_o <= 1'b0;
        ack_o <= 1'b0;
        inv_o <= 1'b0;
    endtask : order
endmodule : host_order_model
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int NSLOT = 6;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sub_valid_i = 1'b0;
    logic [3:0] sub_code_i = 4'h0;
    logic [2:0] sub_port_i = 3'h0;
    logic [15:0] sub_tag_i = 16'h0000;
    logic [3:0] sub_prio_i = 4'h0;
    logic [7:0] break_i = 8'h00;
    logic [7:0] break_report_en_i = 8'hFF;
    logic [7:0] tx_drained_i = 8'h00;
    logic [7:0] tx_event_en_i = 8'h00;
    logic poll_i, event_acknowledge_i, invalidate_i, sub_ready_o, resp_valid_o, active_valid_o;
    logic service_request_o, halt_o;
    logic [7:0] order_pid_i, write_wake_o, resp_pid_o, event_enable_o;
    logic [3:0] inv_code_i, resp_code_o;
    logic [15:0] resp_tag_o, active_tag_o;
    logic [63:0] event_status_o;
    evq_pkg::resp_t resp_kind_o;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;

    always #12.5 mclk_i = ~mclk_i;

    event_queue_status_reporter #(.NSLOT(NSLOT)) i_event_queue_status_reporter (
        .mclk_i(mclk_i), .rst_i(rst_i), .sub_valid_i(sub_valid_i), .sub_ready_o(sub_ready_o),
        .sub_code_i(sub_code_i), .sub_port_i(sub_port_i), .sub_tag_i(sub_tag_i), .sub_prio_i(sub_prio_i),
        .break_i(break_i), .break_report_en_i(break_report_en_i), .tx_drained_i(tx_drained_i),
        .tx_event_en_i(tx_event_en_i), .write_wake_o(write_wake_o),
        .port_identifier_map_i(64'hA7A6A5A4A3A2A1A0), .poll_i(poll_i),
        .event_acknowledge_i(event_acknowledge_i), .invalidate_i(invalidate_i), .order_pid_i(order_pid_i),
        .inv_code_i(inv_code_i), .resp_valid_o(resp_valid_o), .resp_kind_o(resp_kind_o),
        .resp_code_o(resp_code_o), .resp_pid_o(resp_pid_o), .resp_tag_o(resp_tag_o),
        .active_valid_o(active_valid_o), .active_tag_o(active_tag_o), .event_enable_o(event_enable_o),
        .event_status_o(event_status_o), .service_request_o(service_request_o), .halt_o(halt_o));

    host_order_model i_host_order_model (.mclk_i(mclk_i), .poll_o(poll_i), .ack_o(event_acknowledge_i),
        .inv_o(invalidate_i), .pid_o(order_pid_i), .code_o(inv_code_i));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic sub(input logic [3:0] c, input logic [2:0] p, input logic [15:0] t, input logic [3:0] pr);
        @(posedge mclk_i);
        sub_valid_i <= 1'b1;
        sub_code_i <= c;
        sub_port_i <= p;
        sub_tag_i <= t;
        sub_prio_i <= pr;
        @(posedge mclk_i);
        sub_valid_i <= 1'b0;
        #1;
    endtask : sub

    task automatic pulse(input logic [7:0] b, input logic [7:0] d, input logic [7:0] en);
        @(posedge mclk_i);
        break_i <= b;
        tx_drained_i <= d;
        tx_event_en_i <= en;
        @(posedge mclk_i);
        break_i <= 8'h00;
        tx_drained_i <= 8'h00;
        #1;
    endtask : pulse

    task automatic wait_bit(input int idx);
        for (n = 0; n < 20 && event_status_o[idx] !== 1'b1; n++)
            @(posedge mclk_i);
        #1;
    endtask : wait_bit

    task automatic poll(input evq_pkg::resp_t k, input logic [3:0] c, input logic [7:0] p);
        i_host_order_model.order(2'h0, 8'h00, 4'h0);
        #1;
        chk(resp_valid_o, 1'b1);
        chk(service_request_o, 1'b1);
        chk(resp_kind_o, k);
        if (k != evq_pkg::RESP_IDLE)
        begin
            chk(resp_code_o, c);
            chk(resp_pid_o, p);
        end
    endtask : poll

    // Timeout guard
    always @(posedge mclk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            fails++;
            test_done();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1;
        chk(event_enable_o, 8'hFF);
        poll(evq_pkg::RESP_IDLE, 4'h0, 8'h00);
        sub(4'h8, 3'h1, 16'h1234, 4'h8);
        poll(evq_pkg::RESP_QUEUED, 4'h8, 8'hA1);
        chk(resp_tag_o, 16'h1234);
        chk({active_valid_o, active_tag_o}, 17'h11234);
        sub(4'h1, 3'h2, 16'h0000, 4'h2);
        chk({event_enable_o[2], event_status_o[17]}, 2'h1);
        sub(4'h0, 3'h2, 16'h0000, 4'h1);
        chk({event_enable_o[2], event_status_o[16]}, 2'h1);
        pulse(8'h08, 8'h00, 8'h00);
        wait_bit(24);
        chk(event_status_o[24], 1'b1);
        @(posedge mclk_i);
        break_report_en_i <= 8'hDF;
        pulse(8'h20, 8'h00, 8'h00);
        wait_bit(40);
        chk(event_status_o[40], 1'b0);
        poll(evq_pkg::RESP_QUEUED, 4'h0, 8'hA3);
        chk({active_valid_o, event_status_o[24]}, 2'h0);
        poll(evq_pkg::RESP_QUEUED, 4'h1, 8'hA2);
        poll(evq_pkg::RESP_QUEUED, 4'h8, 8'hA1);
        chk({active_valid_o, active_tag_o}, 17'h11234);
        poll(evq_pkg::RESP_ACTIVE, 4'h8, 8'hA1);
        chk(resp_tag_o, 16'h1234);
        i_host_order_model.order(2'h1, 8'hA2, 4'h0);
        poll(evq_pkg::RESP_QUEUED, 4'h0, 8'hA2);
        chk(active_valid_o, 1'b0);
        i_host_order_model.order(2'h1, 8'hA2, 4'h0);
        #1;
        chk(event_enable_o[2], 1'b1);
        poll(evq_pkg::RESP_QUEUED, 4'h8, 8'hA1);
        pulse(8'h00, 8'h10, 8'h00);
        chk(write_wake_o, 8'h10);
        pulse(8'h00, 8'h50, 8'hFF);
        chk(write_wake_o, 8'h00);
        wait_bit(50);
        chk({event_status_o[50], event_status_o[34]}, 2'h3);
        i_host_order_model.order(2'h2, 8'hA4, 4'h2);
        poll(evq_pkg::RESP_QUEUED, 4'h2, 8'hA6);
        i_host_order_model.order(2'h2, 8'hA1, 4'h8);
        poll(evq_pkg::RESP_QUEUED, 4'h8, 8'hA1);
        for (int i = 0; i < NSLOT + 1; i++)
            sub(4'h1, 3'h5, 16'h0000, 4'h2);
        chk(halt_o, 1'b1);
        i_host_order_model.order(2'h0, 8'h00, 4'h0);
        #1;
        chk({service_request_o, resp_valid_o, sub_ready_o}, 3'h0);
        test_done();
    end
endmodule : tb_top

bind event_queue_status_reporter evq_sva #(.NSLOT(NSLOT)) i_evq_sva (.mclk_i(mclk_i), .rst_i(rst_i),
    .sub_valid_i(sub_valid_i), .sub_ready_o(sub_ready_o), .sub_code_i(sub_code_i), .sub_port_i(sub_port_i),
    .tx_drained_i(tx_drained_i), .tx_event_en_i(tx_event_en_i), .write_wake_o(write_wake_o), .poll_i(poll_i),
    .event_acknowledge_i(event_acknowledge_i), .invalidate_i(invalidate_i), .resp_valid_o(resp_valid_o),
    .resp_kind_o(resp_kind_o), .resp_code_o(resp_code_o), .resp_tag_o(resp_tag_o),
    .active_valid_o(active_valid_o), .active_tag_o(active_tag_o), .event_enable_o(event_enable_o),
    .event_status_o(event_status_o), .service_request_o(service_request_o), .halt_o(halt_o));
`default_nettype wire
